// *** rtl/frc_pkg.sv ***
// package: constants, types and register map of the read and recalibrate command engine
package frc_pkg;
  // apb register byte offsets
  localparam logic [7:0] FRC_CMD_OFF = 8'h00;
  localparam logic [7:0] FRC_ID_OFF = 8'h04;
  localparam logic [7:0] FRC_CFG_OFF = 8'h08;
  localparam logic [7:0] FRC_FIFO_OFF = 8'h0c;
  localparam logic [7:0] FRC_RES_OFF = 8'h10;
  localparam logic [7:0] FRC_STAT_OFF = 8'h14;
  localparam logic [7:0] FRC_PTR_OFF = 8'h18;

  // command field layout in the command register
  localparam int FRC_CMD_OP_LSB = 0;
  localparam int FRC_CMD_SK_BIT = 4;
  localparam int FRC_CMD_MT_BIT = 5;
  localparam int FRC_CMD_HD_BIT = 6;
  localparam int FRC_CMD_DRV_LSB = 8;
  localparam int FRC_CMD_EOT_LSB = 16;

  // command codes
  localparam logic [3:0] FRC_OP_READ = 4'h1;
  localparam logic [3:0] FRC_OP_READ_DEL = 4'h2;
  localparam logic [3:0] FRC_OP_READ_ID = 4'h3;
  localparam logic [3:0] FRC_OP_READ_TRACK = 4'h4;
  localparam logic [3:0] FRC_OP_RECAL = 4'h5;

  // configuration bits
  localparam int FRC_CFG_EXTENDED_RECAL_COUNT_BIT = 0;
  localparam int FRC_CFG_WIDE_BIT = 1;
  localparam int FRC_CFG_MOTOR_LSB = 8;

  // recalibrate step limits
  localparam logic [11:0] FRC_RECAL_MAX_STD = 12'd85;
  localparam logic [11:0] FRC_RECAL_MAX_EXT = 12'd255;
  localparam logic [11:0] FRC_RECAL_MAX_WIDE = 12'd3925;
  localparam logic [11:0] FRC_RECAL_MAX_BOTH = 12'd4095;

  // termination codes in status_zero bits 7:6, seek end bit 5
  localparam logic [1:0] FRC_TERM_NORMAL = 2'b00;
  localparam logic [1:0] FRC_TERM_ABNORMAL = 2'b01;
  localparam int FRC_ST0_SEEK_BIT = 5;
  // status_one bits
  localparam int FRC_ST1_EOT_BIT = 7;
  localparam int FRC_ST1_CE_BIT = 5;
  localparam int FRC_ST1_ND_BIT = 2;
  localparam int FRC_ST1_MA_BIT = 0;
  // status_two bits
  localparam int FRC_ST2_CM_BIT = 6;
  localparam int FRC_ST2_CD_BIT = 5;

  // index pulses allowed before a missing address mark
  localparam logic [1:0] FRC_INDEX_LIMIT = 2'd2;
  // step pulse high time and period in cycles
  localparam logic [7:0] FRC_STEP_HIGH = 8'h04;
  localparam logic [7:0] FRC_STEP_PERIOD = 8'h10;
  localparam int FRC_NUM_DRIVES = 4;
  localparam logic [7:0] FRC_FIRST_SECTOR = 8'h01;

  // address field id bytes seen by the data separator
  typedef struct packed {
    logic [7:0] track;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } frc_id_t;

  // one event from the data separator
  typedef struct packed {
    logic id_found;
    logic id_crc_err;
    logic data_found;
    logic data_deleted;
    logic data_crc_err;
    logic sector_done;
    frc_id_t id;
  } frc_sep_t;

  // command fields
  typedef struct packed {
    logic [3:0] op;
    logic skip;
    logic both_sides;
    logic head;
    logic [1:0] drive;
    logic [7:0] last_sector;
  } frc_cmd_t;

  // maximum step count selected by the two configuration bits
  function automatic logic [11:0] frc_recal_max(input logic extended_recal_count, input logic wide);
    case ({wide, extended_recal_count})
      2'b00: frc_recal_max = FRC_RECAL_MAX_STD;
      2'b01: frc_recal_max = FRC_RECAL_MAX_EXT;
      2'b10: frc_recal_max = FRC_RECAL_MAX_WIDE;
      default: frc_recal_max = FRC_RECAL_MAX_BOTH;
    endcase
  endfunction : frc_recal_max
endpackage : frc_pkg

// *** rtl/frc_sync.sv ***
// two flip-flop synchroniser for drive pins
`timescale 1ns/1ps
module frc_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : frc_sync

// *** rtl/frc_stepper.sv ***
// recalibrate step pulse generator, runs while the controller is idle
`timescale 1ns/1ps
module frc_stepper (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [11:0] i_max_steps,
  input wire logic i_track_zero,
  output logic o_step,
  output logic o_busy,
  output logic o_done,
  output logic o_hit_zero
);
  import frc_pkg::*;

  logic [11:0] steps;
  logic [7:0] phase;
  logic next_stop;

  // stop once track zero seen or the limit has been issued
  assign next_stop = i_track_zero || (steps == i_max_steps);

  // step pulses are high for part of each period; a level o_step is simpler than a width counter outside
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      steps <= 12'h000;
      phase <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_hit_zero <= 1'b0;
      o_step <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        steps <= 12'h000;
        phase <= 8'h00;
        o_busy <= 1'b1;
        o_step <= 1'b0;
      end
      else if (o_busy)
      begin
        if (phase == 8'h00 && next_stop)
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_hit_zero <= i_track_zero;
          o_step <= 1'b0;
        end
        else
        begin
          o_step <= (phase < FRC_STEP_HIGH);
          if (phase == FRC_STEP_PERIOD - 8'h01)
          begin
            phase <= 8'h00;
            steps <= steps + 12'h001;
          end
          else
          begin
            phase <= phase + 8'h01;
          end
        end
      end
    end
  end
endmodule : frc_stepper

// *** rtl/frc_engine.sv ***
// command engine for read deleted, read id, read a track and recalibrate with apb registers
`timescale 1ns/1ps
module frc_engine #(
  parameter int MOTOR_CYCLES_DEFAULT = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire frc_pkg::frc_sep_t i_sep,
  input wire logic i_index,
  input wire logic i_track_zero,
  output logic o_step,
  output logic o_step_dir_in,
  output logic o_irq
);
  import frc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MOTOR = 3'b001,
    ST_WAIT_INDEX = 3'b010,
    ST_SEARCH = 3'b011,
    ST_DATA = 3'b100,
    ST_RESULT = 3'b101
  } frc_state_t;

  frc_state_t state;
  frc_cmd_t cmd;
  frc_id_t want;
  frc_id_t res;
  logic [7:0] st0;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [31:0] cfg;
  logic [1:0] index_count;
  logic [15:0] motor_count;
  logic [7:0] track_sectors;
  logic [7:0] ptr [FRC_NUM_DRIVES];
  logic [FRC_NUM_DRIVES-1:0] seek_pending;
  logic seek_irq;
  logic res_irq;
  logic index_s;
  logic index_d;
  logic tz_s;
  logic rec_start;
  logic rec_done;
  logic rec_hit;
  logic rec_busy;
  logic [1:0] rec_drive;

  // pin inputs cross into the system clock first
  frc_sync u_sync_index (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_index),
    .o_sync(index_s)
  );
  frc_sync u_sync_tz (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_track_zero),
    .o_sync(tz_s)
  );

  frc_stepper u_step (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(rec_start),
    .i_max_steps(frc_recal_max(cfg[FRC_CFG_EXTENDED_RECAL_COUNT_BIT], cfg[FRC_CFG_WIDE_BIT])),
    .i_track_zero(tz_s),
    .o_step(o_step),
    .o_busy(rec_busy),
    .o_done(rec_done),
    .o_hit_zero(rec_hit)
  );

  // apb decode, zero wait states
  logic wr_en;
  logic rd_en;
  logic hit;
  logic cmd_wr;
  logic fifo_wr;
  logic res_rd;
  logic index_rise;
  logic is_track;
  logic is_del;
  logic at_last;
  logic wanted_mark;
  logic id_match;
  logic [15:0] motor_cycles;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign hit = (i_paddr == FRC_CMD_OFF) || (i_paddr == FRC_ID_OFF) || (i_paddr == FRC_CFG_OFF)
    || (i_paddr == FRC_FIFO_OFF) || (i_paddr == FRC_RES_OFF) || (i_paddr == FRC_STAT_OFF)
    || (i_paddr == FRC_PTR_OFF);
  assign cmd_wr = wr_en && (i_paddr == FRC_CMD_OFF) && (state == ST_IDLE);
  assign fifo_wr = wr_en && (i_paddr == FRC_FIFO_OFF);
  assign res_rd = rd_en && (i_paddr == FRC_RES_OFF);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_step_dir_in = 1'b0; // recalibrate always steps outward
  assign o_irq = seek_irq || res_irq;
  assign motor_cycles = (cfg[FRC_CFG_MOTOR_LSB +: 16] == 16'h0000) ? MOTOR_CYCLES_DEFAULT[15:0]
    : cfg[FRC_CFG_MOTOR_LSB +: 16];

  // separator helpers
  assign index_rise = index_s && !index_d;
  assign is_track = (cmd.op == FRC_OP_READ_TRACK);
  assign is_del = (cmd.op == FRC_OP_READ_DEL);
  assign at_last = (res.sector == cmd.last_sector);
  // read data wants normal marks, read deleted wants deleted marks
  assign wanted_mark = is_del ? i_sep.data_deleted : !i_sep.data_deleted;
  // compare against the running result id so a side switch searches the new head
  assign id_match = (i_sep.id.track == res.track) && (i_sep.id.head == res.head)
    && (i_sep.id.size == res.size) && (is_track || (i_sep.id.sector == res.sector));

  // register read mux
  always_comb
  begin
    o_prdata = 32'h0000_0000;
    case (i_paddr)
      FRC_CMD_OFF: o_prdata = {8'h00, cmd.last_sector, 6'h00, cmd.drive, 1'b0, cmd.head, cmd.both_sides,
        cmd.skip, cmd.op};
      FRC_ID_OFF: o_prdata = want;
      FRC_CFG_OFF: o_prdata = cfg;
      FRC_RES_OFF: o_prdata = {st0, st1, st2, 8'h00};
      FRC_FIFO_OFF: o_prdata = res;
      FRC_STAT_OFF: o_prdata = {23'h000000, seek_pending, 2'b00, state};
      FRC_PTR_OFF: o_prdata = {ptr[3], ptr[2], ptr[1], ptr[0]};
      default: o_prdata = 32'h0000_0000;
    endcase
  end

  // configuration and id target written by software
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cfg <= 32'h0000_0000;
      want <= '0;
      index_d <= 1'b0;
    end
    else
    begin
      index_d <= index_s;
      if (wr_en && i_paddr == FRC_CFG_OFF)
        cfg <= i_pwdata;
      if (wr_en && i_paddr == FRC_ID_OFF && state == ST_IDLE)
        want <= i_pwdata;
    end
  end

  // present track registers and busy bits; recalibrate zeroes the track, set beats clear for the busy bit
  genvar g;
  generate
    for (g = 0; g < FRC_NUM_DRIVES; g++)
    begin : g_drv
      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          ptr[g] <= 8'h00;
          seek_pending[g] <= 1'b0;
        end
        else
        begin
          if (cmd_wr && i_pwdata[FRC_CMD_OP_LSB +: 4] == FRC_OP_RECAL && i_pwdata[FRC_CMD_DRV_LSB +: 2] == g)
          begin
            ptr[g] <= 8'h00;
            seek_pending[g] <= 1'b1;
          end
          else if (rec_done && rec_drive == g)
            seek_pending[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // seek end interrupt, cleared on first result byte read; a new end wins over the clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      seek_irq <= 1'b0;
    else if (rec_done)
      seek_irq <= 1'b1;
    else if (res_rd)
      seek_irq <= 1'b0;
  end

  // main command sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      cmd <= '0;
      res <= '0;
      st0 <= 8'h00;
      st1 <= 8'h00;
      st2 <= 8'h00;
      index_count <= 2'd0;
      motor_count <= 16'h0000;
      track_sectors <= 8'h00;
      res_irq <= 1'b0;
      rec_start <= 1'b0;
      rec_drive <= 2'd0;
    end
    else
    begin
      rec_start <= 1'b0;
      if (rec_done)
      begin
        st0 <= {FRC_TERM_NORMAL, 1'b1, 3'b000, rec_drive}; // seek end status for sense interrupt
        if (!rec_hit)
          st0[7:6] <= FRC_TERM_ABNORMAL;
      end
      case (state)
        ST_IDLE:
        begin
          if (cmd_wr)
          begin
            cmd <= {i_pwdata[FRC_CMD_OP_LSB +: 4], i_pwdata[FRC_CMD_SK_BIT], i_pwdata[FRC_CMD_MT_BIT],
              i_pwdata[FRC_CMD_HD_BIT], i_pwdata[FRC_CMD_DRV_LSB +: 2], i_pwdata[FRC_CMD_EOT_LSB +: 8]};
            res <= want;
            st0 <= 8'h00;
            st1 <= 8'h00;
            st2 <= 8'h00;
            motor_count <= 16'h0000;
            state <= ST_MOTOR;
          end
        end
        ST_MOTOR:
        begin
          // no implied seek: from motor wait to the search, via the index wait for read a track; recalibrate starts the stepper and goes idle
          if (motor_count == motor_cycles)
          begin
            index_count <= 2'd0;
            track_sectors <= 8'h00;
            if (cmd.op == FRC_OP_RECAL)
            begin
              rec_start <= 1'b1;
              rec_drive <= cmd.drive;
              state <= ST_IDLE;
            end
            else if (is_track)
            begin
              res.sector <= FRC_FIRST_SECTOR;
              state <= ST_WAIT_INDEX;
            end
            else
              state <= ST_SEARCH;
          end
          else
            motor_count <= motor_count + 16'h0001;
        end
        ST_WAIT_INDEX:
        begin
          if (fifo_wr)
          begin
            st0[7:6] <= FRC_TERM_ABNORMAL;
            state <= ST_RESULT;
          end
          else if (index_rise)
            state <= ST_SEARCH;
        end
        ST_SEARCH:
        begin
          if (fifo_wr)
          begin
            st0[7:6] <= FRC_TERM_ABNORMAL;
            state <= ST_RESULT;
          end
          else if (index_rise && index_count == FRC_INDEX_LIMIT - 2'd1 && !is_track)
          begin
            st1[FRC_ST1_MA_BIT] <= 1'b1;
            st0[7:6] <= FRC_TERM_ABNORMAL;
            state <= ST_RESULT;
          end
          else if (i_sep.id_found)
          begin
            if (cmd.op == FRC_OP_READ_ID)
            begin
              res <= i_sep.id;
              state <= ST_RESULT;
            end
            else if (is_track)
            begin
              if (!id_match)
                st1[FRC_ST1_ND_BIT] <= 1'b1;
              if (i_sep.id_crc_err)
                st1[FRC_ST1_CE_BIT] <= 1'b1;
              state <= ST_DATA;
            end
            else if (id_match && !i_sep.id_crc_err)
              state <= ST_DATA;
            else if (i_sep.id_crc_err)
            begin
              st1[FRC_ST1_CE_BIT] <= 1'b1;
              st0[7:6] <= FRC_TERM_ABNORMAL;
              state <= ST_RESULT;
            end
          end
          else if (index_rise)
            index_count <= index_count + 2'd1;
        end
        ST_DATA:
        begin
          if (fifo_wr)
          begin
            st0[7:6] <= FRC_TERM_ABNORMAL;
            state <= ST_RESULT;
          end
          else if (i_sep.data_found && !is_track && !wanted_mark && cmd.skip)
          begin
            st2[FRC_ST2_CM_BIT] <= 1'b1;
            state <= ST_SEARCH;
          end
          else if (i_sep.sector_done)
          begin
            if (!is_track && !wanted_mark)
              st2[FRC_ST2_CM_BIT] <= 1'b1;
            if (i_sep.data_crc_err)
            begin
              st1[FRC_ST1_CE_BIT] <= 1'b1;
              st2[FRC_ST2_CD_BIT] <= 1'b1;
            end
            if (is_track)
            begin
              track_sectors <= track_sectors + 8'h01;
              res.sector <= res.sector + 8'h01;
              if (track_sectors + 8'h01 >= cmd.last_sector)
                state <= ST_RESULT;
              else
                state <= ST_SEARCH;
            end
            else if (i_sep.data_crc_err)
            begin
              st0[7:6] <= FRC_TERM_ABNORMAL;
              state <= ST_RESULT;
            end
            else if (!wanted_mark)
            begin
              res.sector <= res.sector + 8'h01;
              state <= ST_RESULT;
            end
            else if (!at_last)
            begin
              res.sector <= res.sector + 8'h01;
              state <= ST_SEARCH;
            end
            else if (cmd.both_sides && !res.head[0])
            begin
              res.head <= 8'h01;
              res.sector <= FRC_FIRST_SECTOR;
              state <= ST_SEARCH;
            end
            else
            begin
              res.track <= res.track + 8'h01;
              res.head <= cmd.both_sides ? 8'h00 : res.head;
              res.sector <= FRC_FIRST_SECTOR;
              st1[FRC_ST1_EOT_BIT] <= 1'b1;
              st0[7:6] <= FRC_TERM_ABNORMAL;
              state <= ST_RESULT;
            end
          end
        end
        ST_RESULT:
        begin
          res_irq <= 1'b1;
          if (res_rd)
          begin
            res_irq <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : frc_engine

// *** dv/frc_chk.sv ***
// port checker for the read and recalibrate command engine
`timescale 1ns/1ps
module frc_chk import frc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_track_zero,
  input wire logic o_step,
  input wire logic o_step_dir_in,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // access phase and the seven mapped words
  wire acc = i_psel && i_penable;
  wire mapped = i_paddr[1:0] == 2'b00 && i_paddr <= FRC_PTR_OFF;
  sequence step_pulse;
    o_step [*4] ##1 !o_step;
  endsequence
  sequence step_gap;
    !o_step [*8];
  endsequence
  a_zero_wait: assert property (acc |-> o_pready)
    else $error("pready low in access");
  a_slverr_bad: assert property (acc && !mapped |-> o_pslverr)
    else $error("no slverr on unmapped");
  a_slverr_good: assert property (acc && mapped |-> !o_pslverr)
    else $error("slverr on mapped");
  a_dir_out: assert property (!o_step_dir_in)
    else $error("step direction inward");
  a_step_high: assert property ($rose(o_step) |-> step_pulse)
    else $error("step high time");
  a_step_gap: assert property ($fell(o_step) |-> step_gap)
    else $error("step period short");
  a_irq_quiet: assert property (o_step |-> !o_irq)
    else $error("irq while stepping");
  // synchroniser delay is well inside eight cycles
  a_zero_stop: assert property (i_track_zero [*8] |-> !$rose(o_step))
    else $error("step at track zero");
  a_irq_clear: assert property (acc && !i_pwrite && i_paddr == FRC_RES_OFF |-> ##[1:2] !o_irq)
    else $error("irq kept after result read");
endmodule : frc_chk
bind frc_engine frc_chk chk_u (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready,
  .o_pslverr, .i_track_zero, .o_step, .o_step_dir_in, .o_irq);

// *** dv/frc_drive_model.sv ***
// drive model: separator events, free index pulse, track zero
`timescale 1ns/1ps
module frc_drive_model import frc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_start,
  input wire logic i_with_id,
  input wire logic i_index_en,
  input wire logic i_deleted,
  input wire logic i_crc_bad,
  input wire frc_pkg::frc_id_t i_id,
  input wire logic [7:0] i_eot,
  input wire logic [11:0] i_tz_after,
  input wire logic i_step,
  output frc_pkg::frc_sep_t o_sep,
  output logic o_index,
  output logic o_track_zero
);
  logic [8:0] tick = 0;
  logic [11:0] steps = 0;
  logic step_q = 0;
  frc_id_t cur = 0;
  // one sector every 64 cycles: id at 10, data at 20, end at 30
  wire sec_on = i_with_id && tick[5:0] == 6'h1e;
  always_ff @(posedge i_clk_sys)
  begin
    tick <= i_start ? 9'h000 : tick + 9'h001;
    step_q <= i_step;
    steps <= i_start ? 12'h000 : steps + 12'(i_step && !step_q);
    if (i_start)
      cur <= i_id;
    else if (sec_on)
      cur.sector <= cur.sector == i_eot ? FRC_FIRST_SECTOR : cur.sector + 8'h01;
    if (sec_on && cur.sector == i_eot)
      cur.head <= cur.head ^ 8'h01;
  end
  wire id_on = i_with_id && tick[5:0] == 6'h0a;
  // released id lines show the inverse, never a stale copy; one driver for the whole struct
  assign o_sep = {id_on, 1'b0, i_with_id && tick[5:0] == 6'h14, i_deleted, sec_on && i_crc_bad, sec_on,
    id_on ? cur : ~cur};
  // index high four cycles per turn while the disk spins
  assign o_index = i_index_en && tick[8:2] == 7'h7d;
  assign o_track_zero = steps >= i_tz_after;
endmodule : frc_drive_model

// *** dv/testbench.sv ***
// self-checking bench for the read and recalibrate engine
`timescale 1ns/1ps
module testbench;
  import frc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, er;
  logic wid = 0, idx = 0, del = 0, bad = 0, stp_q = 0;
  logic [7:0] pa = 0, last_sector_number = 8'hff;
  logic [31:0] pwd = 0, rd;
  logic [11:0] tz = 12'hfff;
  frc_id_t id = 0, cid;
  frc_sep_t sep;
  wire [31:0] prd;
  wire rdy, err, stp, dir, irq, ix, t0;
  int seed = 32'hc7ee, n_fail = 0, num_checks = 0, n_stp = 0, k;
  frc_engine dut_u (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_sep(sep),
    .i_index(ix), .i_track_zero(t0), .o_step(stp), .o_step_dir_in(dir), .o_irq(irq));
  frc_drive_model drv_u (.i_clk_sys(clk), .i_start(go), .i_with_id(wid), .i_index_en(idx),
    .i_deleted(del), .i_crc_bad(bad), .i_id(id), .i_eot(last_sector_number), .i_tz_after(tz), .i_step(stp),
    .o_sep(sep), .o_index(ix), .o_track_zero(t0));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // step pulses counted from each command start
  always @(posedge clk)
  begin
    stp_q <= stp;
    n_stp <= go ? 0 : n_stp + (stp && !stp_q);
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // an edge passes first, so a strobe is never assigned twice per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    // only the watchdog ends a wait for pready
    while (rdy !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prd;
    er = err;
    psel <= 0;
    pen <= 0;
  endtask : apb
  // drive model restarts while the command word is written
  task cmd(input logic [3:0] op, input logic mt, input logic hd, input logic [1:0] dv);
    @(posedge clk);
    go <= 1;
    apb(1, FRC_CMD_OFF, {8'h00, last_sector_number, 6'h00, dv, 1'b0, hd, mt, 1'b0, op});
    go <= 0;
  endtask : cmd
  task wirq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      n++;
      @(posedge clk);
    end
    chk("irq", 1, irq);
  endtask : wirq
  task fin(input logic [31:0] m, input logic [31:0] e);
    apb(0, FRC_RES_OFF, 0);
    chk("result", e, rd & m);
  endtask : fin
  task fid(input frc_id_t e);
    apb(0, FRC_FIFO_OFF, 0);
    chk("id", e, rd);
  endtask : fid
  // result id after the last sector handled
  function automatic frc_id_t nxt(frc_id_t c, logic mt);
    nxt = c;
    nxt.sector = c.sector + 8'h01;
    if (c.sector == last_sector_number)
    begin
      nxt.sector = FRC_FIRST_SECTOR;
      nxt.head = {7'h00, mt && !c.head[0]};
      nxt.track = c.track + 8'(!(mt && !c.head[0]));
      if (!mt)
        nxt.head = c.head;
    end
  endfunction : nxt
  task complete_run;
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, FRC_STAT_OFF, 0);
    chk("stat", 0, rd);
    apb(0, 8'h1c, 0);
    chk("slverr", 1, er);
    // first id passes before the motor time ends
    cid = $random(seed);
    cid.sector = 8'h10;
    id <= cid;
    wid <= 1;
    cmd(FRC_OP_READ_ID, 0, 0, 0);
    wirq(500);
    fid(cid + 32'h100);
    fin(32'hc0000000, 0);
    wid <= 0;
    idx <= 1;
    cmd(FRC_OP_READ_ID, 0, 0, 0);
    wirq(3000);
    fin(32'hc0010000, 32'h40010000);
    // a fifo write releases a search or an index wait
    idx <= 0;
    for (k = 0; k < 2; k++)
    begin
      cmd(k ? FRC_OP_READ_TRACK : FRC_OP_READ_ID, 0, 0, 0);
      repeat (60) @(posedge clk);
      apb(1, FRC_FIFO_OFF, 0);
      wirq(50);
      fin(32'hc0000000, 32'h40000000);
    end
    wid <= 1;
    idx <= 1;
    bad <= 1;
    last_sector_number <= 8'h03;
    cid = $random(seed);
    cid.head = 8'h01;
    cid.sector = 8'h40;
    id <= cid;
    apb(1, FRC_ID_OFF, {cid.track, 16'h0001, cid.size});
    cmd(FRC_OP_READ_TRACK, 0, 0, 0);
    wirq(2000);
    fid({cid.track, 8'h00, 8'h04, cid.size});
    fin(32'h00242000, 32'h00242000);
    bad <= 0;
    last_sector_number <= 8'h20;
    cid.head = 8'h00;
    cid.sector = 8'h05;
    id <= cid;
    apb(1, FRC_ID_OFF, cid + 32'h100);
    cmd(FRC_OP_READ_DEL, 0, 0, 0);
    wirq(500);
    fid(nxt(cid + 32'h100, 0));
    fin(32'h00004000, 32'h00004000);
    // short track so both sides of a multi-side read fit in one run
    del <= 1;
    last_sector_number <= 8'h02;
    for (k = 0; k < 4; k++)
    begin
      cid = $random(seed);
      cid.head = {7'h00, k == 1 || k == 2};
      cid.sector = 8'h00;
      id <= cid;
      apb(1, FRC_ID_OFF, cid + 32'h100);
      cmd(FRC_OP_READ_DEL, k[1], cid.head[0], 0);
      wirq(800);
      cid = cid + 32'h100;
      repeat (k == 3 ? 4 : 2) cid = nxt(cid, k[1]);
      fid(cid);
      fin(32'h00800000, 32'h00800000);
    end
    for (k = 0; k < 3; k++)
    begin
      tz <= k ? 12'hfff : 12'd1 + 12'($random(seed) & 15);
      apb(1, FRC_CFG_OFF, k == 2);
      cmd(FRC_OP_RECAL, 0, 0, k[1:0]);
      apb(0, FRC_STAT_OFF, 0);
      chk("busy", 1, rd[5 + k]);
      wirq(5000);
      chk("steps", k ? (k == 2 ? FRC_RECAL_MAX_EXT : FRC_RECAL_MAX_STD) : tz, n_stp);
      fin(32'hff000000, {k ? 2'b01 : 2'b00, 4'h8, k[1:0], 24'h0});
      apb(0, FRC_PTR_OFF, 0);
      chk("ptr", 0, rd[8 * k +: 8]);
    end
    complete_run;
  end
endmodule : testbench
